// ==== tdwi_regs.svh ====
`ifndef TDWI_REGS_SVH
`define TDWI_REGS_SVH

`define TDWI_ADDR_W     18
`define TDWI_DATA_W     32
`define TDWI_LANE_W     4
`define TDWI_DMA_CYCLES 2
`define TDWI_CNT_W      4
`define TDWI_SIDE_DATA  0
`define TDWI_SIDE_INSTR 1

`endif

// ==== tdwi_pkg.sv ====
`include "tdwi_regs.svh"

package tdwi_pkg;

    typedef enum {
        TDWI_WAIT_NONE,
        TDWI_WAIT_NSEQ,
        TDWI_WAIT_EVERY
    } tdwi_wait_mode_type;

    typedef enum {
        TDWI_WS_WAIT,
        TDWI_WS_COMPLETE
    } tdwi_ws_type;

    typedef struct packed {
        logic                     request;
        logic                     seq;
        logic                     idle;
        logic [`TDWI_ADDR_W-1:0]  addr;
        logic [`TDWI_LANE_W-1:0]  lanes;
        logic                     wnr;
        logic [`TDWI_DATA_W-1:0]  wdata;
    } tdwi_proc_type;

    typedef struct packed {
        logic                     valid;
        logic                     wnr;
        logic [`TDWI_ADDR_W-1:0]  addr;
        logic [`TDWI_LANE_W-1:0]  lanes;
        logic [`TDWI_DATA_W-1:0]  wdata;
    } tdwi_dma_req_type;

    typedef struct packed {
        logic                     cs;
        logic [`TDWI_ADDR_W-1:0]  addr;
        logic [`TDWI_LANE_W-1:0]  lanes;
        logic                     wnr;
        logic [`TDWI_DATA_W-1:0]  wdata;
    } tdwi_mem_type;

endpackage : tdwi_pkg

// ==== tdwi_wait_fsm.sv ====
`timescale 1ns/1ps

module tdwi_wait_fsm
    import tdwi_pkg::*;
(
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic request,
    output logic      wait_level
);

    tdwi_ws_type state;
    tdwi_ws_type next_state;

    always_comb begin
        next_state = state;
        case (state)
            TDWI_WS_WAIT: begin
                if (request) begin
                    next_state = TDWI_WS_COMPLETE;
                end
            end
            TDWI_WS_COMPLETE: begin
                next_state = TDWI_WS_WAIT;
            end
            default: begin
                next_state = TDWI_WS_WAIT;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state <= TDWI_WS_WAIT;
        end else begin
            state <= next_state;
        end
    end

    assign wait_level = (state == TDWI_WS_WAIT);

endmodule : tdwi_wait_fsm

// ==== tdwi_subsystem.sv ====
`timescale 1ns/1ps
`include "tdwi_regs.svh"

// Operation
// - DMA select is raised together with override, on data side whether or not port is idle
// - lane mask, direction and write data are multiplexed outside the port
// - instruction side DMA only while port idle or in standby
// - wait sampled in a cycle applies to the following data cycle
// - two-state generator gives one wait per instruction access
// - inverted sequential flag fed to wait gives nonsequential wait
// - wait stalls the port for memory waits and while DMA holds memory
// - attributes of a request postponed by DMA are captured that cycle
// - resumed postponed access is forced nonsequential, one extra wait
// - memory inputs come from port, DMA or capture register
// - memory asserts wait in request cycle, drops it one cycle early
module tdwi_subsystem
    import tdwi_pkg::*;
#(
    parameter tdwi_wait_mode_type DATA_WAIT  = TDWI_WAIT_NSEQ,
    parameter tdwi_wait_mode_type INSTR_WAIT = TDWI_WAIT_EVERY,
    parameter logic [`TDWI_CNT_W-1:0] DMA_CYCLES = `TDWI_DMA_CYCLES
) (
    input  wire logic                    mclk,
    input  wire logic                    rst,
    input  wire logic                    boot_strap,
    input  wire logic                    hivec_strap,
    output logic                         tcm_boot_enable,
    output logic                         high_vector_select,
    input  wire logic                    standby_wait_for_irq,
    input  wire logic                    data_mem_request,
    input  wire logic                    data_seq_flag,
    input  wire logic                    data_ctrl_idle,
    input  wire logic [`TDWI_ADDR_W-1:0] data_mem_word_addr,
    input  wire logic [`TDWI_LANE_W-1:0] data_byte_lane_mask,
    input  wire logic                    data_write_not_read,
    input  wire logic [`TDWI_DATA_W-1:0] data_write_data,
    output logic                         data_dma_override,
    output logic                         data_dma_select_in,
    output logic [`TDWI_ADDR_W-1:0]      data_dma_word_addr,
    output logic                         data_wait_in,
    output tdwi_mem_type                 data_mem,
    input  wire logic [`TDWI_DATA_W-1:0] data_mem_rdata,
    input  wire tdwi_dma_req_type        data_dma,
    output logic                         data_dma_accept,
    output logic                         data_dma_done,
    output logic [`TDWI_DATA_W-1:0]      data_dma_rdata,
    input  wire logic                    instr_mem_request,
    input  wire logic                    instr_seq_flag,
    input  wire logic                    instr_ctrl_idle,
    input  wire logic [`TDWI_ADDR_W-1:0] instr_mem_word_addr,
    input  wire logic [`TDWI_LANE_W-1:0] instr_byte_lane_mask,
    input  wire logic                    instr_write_not_read,
    input  wire logic [`TDWI_DATA_W-1:0] instr_write_data,
    output logic                         instr_dma_override,
    output logic                         instr_dma_select_in,
    output logic [`TDWI_ADDR_W-1:0]      instr_dma_word_addr,
    output logic                         instr_wait_in,
    output tdwi_mem_type                 instr_mem,
    input  wire logic [`TDWI_DATA_W-1:0] instr_mem_rdata,
    input  wire tdwi_dma_req_type        instr_dma,
    output logic                         instr_dma_accept,
    output logic                         instr_dma_done,
    output logic [`TDWI_DATA_W-1:0]      instr_dma_rdata
);

    tdwi_proc_type           proc     [2];
    tdwi_dma_req_type        dma_in   [2];
    logic [`TDWI_DATA_W-1:0] rdata_in [2];
    logic                    may_dma  [2];
    logic                    ovr      [2];
    logic [`TDWI_ADDR_W-1:0] dma_addr [2];
    logic                    waitv    [2];
    tdwi_mem_type            mem_out  [2];
    logic                    accept   [2];
    logic                    done     [2];
    logic [`TDWI_DATA_W-1:0] rdata    [2];
    logic                    next_boot;
    logic                    next_hivec;

    assign proc[`TDWI_SIDE_DATA]  = '{data_mem_request, data_seq_flag,
                                      data_ctrl_idle, data_mem_word_addr,
                                      data_byte_lane_mask,
                                      data_write_not_read, data_write_data};
    assign proc[`TDWI_SIDE_INSTR] = '{instr_mem_request, instr_seq_flag,
                                      instr_ctrl_idle, instr_mem_word_addr,
                                      instr_byte_lane_mask,
                                      instr_write_not_read, instr_write_data};
    assign dma_in[`TDWI_SIDE_DATA]    = data_dma;
    assign dma_in[`TDWI_SIDE_INSTR]   = instr_dma;
    assign rdata_in[`TDWI_SIDE_DATA]  = data_mem_rdata;
    assign rdata_in[`TDWI_SIDE_INSTR] = instr_mem_rdata;
    assign may_dma[`TDWI_SIDE_DATA]   = 1'b1;
    assign may_dma[`TDWI_SIDE_INSTR]  = instr_ctrl_idle
                                      | standby_wait_for_irq;

    generate
        for (genvar s = 0; s < 2; s++) begin : g_side
            logic [`TDWI_CNT_W-1:0] cnt;
            logic [`TDWI_CNT_W-1:0] next_cnt;
            logic                   next_ovr;
            logic [`TDWI_ADDR_W-1:0] next_addr;
            logic                   pending;
            logic                   next_pending;
            tdwi_mem_type           cap;
            tdwi_mem_type           next_cap;
            tdwi_dma_req_type       held;
            tdwi_dma_req_type       next_held;
            logic                   next_accept;
            logic                   next_done;
            logic [`TDWI_DATA_W-1:0] next_rdata;
            logic                   stall;
            logic                   resume;
            logic                   start;
            logic                   fsm_wait;
            logic                   base_wait;

            tdwi_wait_fsm u_fsm (
                .mclk       (mclk),
                .rst        (rst),
                .request    (proc[s].request),
                .wait_level (fsm_wait)
            );

            assign stall  = (cnt != '0);
            assign resume = pending & ~stall;
            assign start  = dma_in[s].valid & may_dma[s] & ~stall
                          & ~pending & ~ovr[s];

            always_comb begin
                if (s == `TDWI_SIDE_DATA) begin
                    if (DATA_WAIT == TDWI_WAIT_NSEQ) begin
                        base_wait = ~proc[s].seq;
                    end else if (DATA_WAIT == TDWI_WAIT_EVERY) begin
                        base_wait = fsm_wait;
                    end else begin
                        base_wait = 1'b0;
                    end
                end else begin
                    if (INSTR_WAIT == TDWI_WAIT_NSEQ) begin
                        base_wait = ~proc[s].seq;
                    end else if (INSTR_WAIT == TDWI_WAIT_EVERY) begin
                        base_wait = fsm_wait;
                    end else begin
                        base_wait = 1'b0;
                    end
                end
            end

            // speculative wait: the port ignores it outside accesses
            assign waitv[s] = stall | resume | base_wait;

            always_comb begin
                mem_out[s].cs = resume
                              | (proc[s].request & (ovr[s] | ~stall));
                if (resume) begin
                    mem_out[s].addr  = cap.addr;
                    mem_out[s].lanes = cap.lanes;
                    mem_out[s].wnr   = cap.wnr;
                    mem_out[s].wdata = cap.wdata;
                end else if (ovr[s]) begin
                    mem_out[s].addr  = proc[s].addr;
                    mem_out[s].lanes = held.lanes;
                    mem_out[s].wnr   = held.wnr;
                    mem_out[s].wdata = held.wdata;
                end else begin
                    mem_out[s].addr  = proc[s].addr;
                    mem_out[s].lanes = proc[s].lanes;
                    mem_out[s].wnr   = proc[s].wnr;
                    mem_out[s].wdata = proc[s].wdata;
                end
            end

            always_comb begin
                next_cnt     = stall ? cnt - 1'b1 : cnt;
                next_ovr     = 1'b0;
                next_addr    = dma_addr[s];
                next_held    = held;
                next_accept  = 1'b0;
                next_done    = 1'b0;
                next_rdata   = rdata[s];
                next_pending = pending;
                next_cap     = cap;
                if (start) begin
                    next_ovr    = 1'b1;
                    next_addr   = dma_in[s].addr;
                    next_held   = dma_in[s];
                    next_accept = 1'b1;
                    next_cnt    = DMA_CYCLES;
                end
                if (cnt == `TDWI_CNT_W'(1)) begin
                    next_done = 1'b1;
                    if (!held.wnr) begin
                        next_rdata = rdata_in[s];
                    end
                end
                if (proc[s].request & stall & ~ovr[s]) begin
                    next_pending = 1'b1;
                    next_cap = '{1'b1, proc[s].addr, proc[s].lanes,
                                 proc[s].wnr, proc[s].wdata};
                end else if (resume) begin
                    next_pending = 1'b0;
                end
            end

            always_ff @(posedge mclk) begin
                if (rst) begin
                    cnt         <= '0;
                    ovr[s]      <= 1'b0;
                    dma_addr[s] <= '0;
                    held        <= '0;
                    accept[s]   <= 1'b0;
                    done[s]     <= 1'b0;
                    rdata[s]    <= '0;
                    pending     <= 1'b0;
                    cap         <= '0;
                end else begin
                    cnt         <= next_cnt;
                    ovr[s]      <= next_ovr;
                    dma_addr[s] <= next_addr;
                    held        <= next_held;
                    accept[s]   <= next_accept;
                    done[s]     <= next_done;
                    rdata[s]    <= next_rdata;
                    pending     <= next_pending;
                    cap         <= next_cap;
                end
            end
        end
    endgenerate

    assign data_dma_override    = ovr[`TDWI_SIDE_DATA];
    assign data_dma_select_in   = ovr[`TDWI_SIDE_DATA];
    assign data_dma_word_addr   = dma_addr[`TDWI_SIDE_DATA];
    assign data_wait_in         = waitv[`TDWI_SIDE_DATA];
    assign data_mem             = mem_out[`TDWI_SIDE_DATA];
    assign data_dma_accept      = accept[`TDWI_SIDE_DATA];
    assign data_dma_done        = done[`TDWI_SIDE_DATA];
    assign data_dma_rdata       = rdata[`TDWI_SIDE_DATA];
    assign instr_dma_override   = ovr[`TDWI_SIDE_INSTR];
    assign instr_dma_select_in  = ovr[`TDWI_SIDE_INSTR];
    assign instr_dma_word_addr  = dma_addr[`TDWI_SIDE_INSTR];
    assign instr_wait_in        = waitv[`TDWI_SIDE_INSTR];
    assign instr_mem            = mem_out[`TDWI_SIDE_INSTR];
    assign instr_dma_accept     = accept[`TDWI_SIDE_INSTR];
    assign instr_dma_done       = done[`TDWI_SIDE_INSTR];
    assign instr_dma_rdata      = rdata[`TDWI_SIDE_INSTR];

    // straps follow the board every cycle, reset included
    always_comb begin
        next_boot  = boot_strap;
        next_hivec = hivec_strap;
    end

    always_ff @(posedge mclk) begin
        tcm_boot_enable    <= next_boot;
        high_vector_select <= next_hivec;
    end

endmodule : tdwi_subsystem

// ==== tdwi_sva.sv ====
`timescale 1ns/1ps
`include "tdwi_regs.svh"

module tdwi_sva
    import tdwi_pkg::*;
#(
    parameter logic [`TDWI_CNT_W-1:0] DMA_CYCLES = `TDWI_DMA_CYCLES
) (
    input wire logic                    mclk,
    input wire logic                    rst,
    input wire logic                    boot_strap,
    input wire logic                    hivec_strap,
    input wire logic                    tcm_boot_enable,
    input wire logic                    high_vector_select,
    input wire logic                    standby_wait_for_irq,
    input wire logic                    data_mem_request,
    input wire logic                    data_seq_flag,
    input wire logic                    data_dma_override,
    input wire logic                    data_dma_select_in,
    input wire logic [`TDWI_ADDR_W-1:0] data_dma_word_addr,
    input wire logic                    data_wait_in,
    input wire tdwi_mem_type            data_mem,
    input wire tdwi_dma_req_type        data_dma,
    input wire logic                    data_dma_accept,
    input wire logic                    data_dma_done,
    input wire logic                    instr_ctrl_idle,
    input wire logic                    instr_dma_accept
);
    localparam int DC = DMA_CYCLES;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_select_with_override: assert property (
        data_dma_override |-> data_dma_select_in && data_dma_accept
            && $past(data_dma.valid))
        else $error("override without select");
    a_resume_forced: assert property (
        data_dma_done && $past(data_mem_request && !data_mem.cs)
            |-> data_mem.cs && data_wait_in)
        else $error("postponed access not resumed");
    a_dma_addr_path: assert property (
        data_dma_override |-> data_dma_word_addr == $past(data_dma.addr)
            && data_mem.addr == data_dma_word_addr)
        else $error("dma address not passed to memory");
    a_dma_attr_mux: assert property (
        data_dma_override |-> data_mem.lanes == $past(data_dma.lanes)
            && data_mem.wnr == $past(data_dma.wnr))
        else $error("dma attributes not selected");
    a_override_pulse: assert property (
        data_dma_override |=> !data_dma_override)
        else $error("override longer than one cycle");
    a_done_timing: assert property (
        data_dma_accept |-> ##DC data_dma_done)
        else $error("dma done late or early");
    a_wait_busy: assert property (
        data_dma_accept |-> data_wait_in ##1 data_wait_in)
        else $error("wait low while dma holds memory");
    a_busy_masks_cs: assert property (
        data_dma_accept ##1 data_mem_request |-> !data_mem.cs)
        else $error("port request reached memory during dma");
    a_loopback_wait: assert property (
        !data_wait_in |-> data_seq_flag)
        else $error("nonsequential access not waited");
    a_instr_idle: assert property (
        instr_dma_accept |-> $past(instr_ctrl_idle || standby_wait_for_irq))
        else $error("instr dma taken while port busy");
    a_boot_copy: assert property (
        tcm_boot_enable == $past(boot_strap)
            && high_vector_select == $past(hivec_strap))
        else $error("boot pins do not follow straps");
endmodule : tdwi_sva

bind tdwi_subsystem tdwi_sva #(.DMA_CYCLES(DMA_CYCLES)) u_sva (
    .mclk, .rst, .boot_strap, .hivec_strap, .tcm_boot_enable,
    .high_vector_select, .standby_wait_for_irq, .data_mem_request,
    .data_seq_flag, .data_dma_override, .data_dma_select_in,
    .data_dma_word_addr, .data_wait_in, .data_mem, .data_dma,
    .data_dma_accept, .data_dma_done, .instr_ctrl_idle, .instr_dma_accept
);

// ==== tdwi_port_model.sv ====
`timescale 1ns/1ps
`include "tdwi_regs.svh"

module tdwi_port_model
    import tdwi_pkg::*;
(
    input  wire logic                    mclk,
    input  wire logic                    rst,
    input  wire logic                    want,
    input  wire logic                    want_seq,
    input  wire logic [`TDWI_ADDR_W-1:0] want_addr,
    input  wire logic                    override,
    input  wire logic                    select_in,
    input  wire logic [`TDWI_ADDR_W-1:0] dma_addr,
    input  wire logic                    wait_in,
    output logic                         request,
    output logic                         seq,
    output logic                         idle,
    output logic [`TDWI_ADDR_W-1:0]      addr,
    output logic                         taken
);
    logic waited, next_waited, lost, next_lost;

    always_comb begin
        taken = want && !waited && !override;
        request = override ? select_in : taken;
        addr = override ? dma_addr : want_addr;
        seq = !override && (waited || (want_seq && !lost));
        idle = !want && !waited;
        next_waited = (taken || waited) && wait_in;
        next_lost = (override && want) || (lost && !taken);
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            waited <= 1'b0;
            lost <= 1'b0;
        end else begin
            waited <= next_waited;
            lost <= next_lost;
        end
    end
endmodule : tdwi_port_model

// ==== tb.sv ====
`timescale 1ns/1ps
`include "tdwi_regs.svh"

module tb
    import tdwi_pkg::*;
;
    logic mclk, rst, boot_strap, hivec_strap, tcm_boot_enable;
    logic high_vector_select, standby_wait_for_irq, d_want, d_seq, i_want;
    logic data_mem_request, data_seq_flag, data_ctrl_idle;
    logic instr_mem_request, instr_seq_flag, instr_ctrl_idle;
    logic data_write_not_read, instr_write_not_read;
    logic data_dma_override, data_dma_select_in, data_wait_in;
    logic instr_dma_override, instr_dma_select_in, instr_wait_in;
    logic data_dma_accept, data_dma_done, instr_dma_accept, instr_dma_done;
    logic [`TDWI_ADDR_W-1:0] data_mem_word_addr, data_dma_word_addr, d_addr;
    logic [`TDWI_ADDR_W-1:0] instr_mem_word_addr, instr_dma_word_addr;
    logic [`TDWI_LANE_W-1:0] data_byte_lane_mask, instr_byte_lane_mask;
    logic [`TDWI_DATA_W-1:0] data_write_data, instr_write_data;
    logic [`TDWI_DATA_W-1:0] data_mem_rdata, data_dma_rdata;
    logic [`TDWI_DATA_W-1:0] instr_mem_rdata, instr_dma_rdata;
    tdwi_mem_type            data_mem, instr_mem;
    tdwi_dma_req_type        data_dma, instr_dma;
    int                      num_errors = 0;
    int                      samples_checked = 0;

    tdwi_subsystem u_dut (
        .mclk, .rst, .boot_strap, .hivec_strap, .tcm_boot_enable,
        .high_vector_select, .standby_wait_for_irq, .data_mem_request,
        .data_seq_flag, .data_ctrl_idle, .data_mem_word_addr,
        .data_byte_lane_mask, .data_write_not_read, .data_write_data,
        .data_dma_override, .data_dma_select_in, .data_dma_word_addr,
        .data_wait_in, .data_mem, .data_mem_rdata, .data_dma,
        .data_dma_accept, .data_dma_done, .data_dma_rdata,
        .instr_mem_request, .instr_seq_flag, .instr_ctrl_idle,
        .instr_mem_word_addr, .instr_byte_lane_mask, .instr_write_not_read,
        .instr_write_data, .instr_dma_override, .instr_dma_select_in,
        .instr_dma_word_addr, .instr_wait_in, .instr_mem, .instr_mem_rdata,
        .instr_dma, .instr_dma_accept, .instr_dma_done, .instr_dma_rdata
    );

    tdwi_port_model u_dport (
        .mclk, .rst, .want(d_want), .want_seq(d_seq), .want_addr(d_addr),
        .override(data_dma_override), .select_in(data_dma_select_in),
        .dma_addr(data_dma_word_addr), .wait_in(data_wait_in),
        .request(data_mem_request), .seq(data_seq_flag),
        .idle(data_ctrl_idle), .addr(data_mem_word_addr), .taken()
    );

    tdwi_port_model u_iport (
        .mclk, .rst, .want(i_want), .want_seq(1'b0), .want_addr(18'h00040),
        .override(instr_dma_override), .select_in(instr_dma_select_in),
        .dma_addr(instr_dma_word_addr), .wait_in(instr_wait_in),
        .request(instr_mem_request), .seq(instr_seq_flag),
        .idle(instr_ctrl_idle), .addr(instr_mem_word_addr), .taken()
    );

    // single-cycle sram: data returned the cycle after the access
    always @(posedge mclk) begin
        data_mem_rdata <= {14'h0, data_mem.addr};
        instr_mem_rdata <= {14'h0, instr_mem.addr};
    end

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic step(input int n = 1);
        repeat (n) @(posedge mclk);
        #1;
    endtask : step

    task automatic cmp_bit(input string what, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s exp %b got %b", what, exp, got);
        end
    endtask : cmp_bit

    task automatic cmp_word(input string what,
                            input logic [`TDWI_DATA_W-1:0] exp,
                            input logic [`TDWI_DATA_W-1:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s exp %h got %h", what, exp, got);
        end
    endtask : cmp_word

    task automatic stop_test;
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test

    task automatic t_boot;
        for (int i = 0; i < 4; i++) begin
            {hivec_strap, boot_strap} = i[1:0];
            step(2);
            cmp_bit("boot enable", i[0], tcm_boot_enable);
            cmp_bit("high vector", i[1], high_vector_select);
        end
        $display("t_boot done");
    endtask : t_boot

    task automatic t_dma_idle;
        data_dma = {1'b1, 1'b0, 18'h2A5C3, 4'h0, 32'h0};
        step();
        data_dma.valid = 1'b0;
        #1;
        cmp_bit("dma accept", 1'b1, data_dma_accept);
        cmp_bit("mem cs", 1'b1, data_mem.cs);
        cmp_word("mem addr", 32'h0002A5C3, {14'h0, data_mem.addr});
        step(2);
        cmp_bit("dma done", 1'b1, data_dma_done);
        cmp_word("dma rdata", 32'h0002A5C3, data_dma_rdata);
        $display("t_dma_idle done");
    endtask : t_dma_idle

    task automatic t_dma_stall;
        data_dma = {1'b1, 1'b1, 18'h00ABC, 4'hF, 32'hCAFE0001};
        step();
        data_dma.valid = 1'b0;
        {d_want, d_seq, d_addr} = {1'b1, 1'b1, 18'h000B2};
        {data_byte_lane_mask, data_write_not_read} = {4'h5, 1'b1};
        data_write_data = 32'h00005A5A;
        cmp_word("dma wdata", 32'hCAFE0001, data_mem.wdata);
        cmp_word("dma lanes", 32'h0000000F, {28'h0, data_mem.lanes});
        step();
        cmp_bit("cs masked", 1'b0, data_mem.cs);
        cmp_bit("busy wait", 1'b1, data_wait_in);
        step();
        {d_want, data_byte_lane_mask, data_write_not_read} = '0;
        data_write_data = '0;
        #1;
        cmp_bit("resume cs", 1'b1, data_mem.cs);
        cmp_word("resume addr", 32'h000000B2, {14'h0, data_mem.addr});
        cmp_word("resume lanes", 32'h5, {28'h0, data_mem.lanes});
        cmp_bit("resume wnr", 1'b1, data_mem.wnr);
        cmp_word("resume wdata", 32'h00005A5A, data_mem.wdata);
        cmp_bit("forced wait", 1'b1, data_wait_in);
        step();
        cmp_bit("wait drop", 1'b0, data_wait_in);
        step();
        d_want = 1'b1;
        #1;
        cmp_bit("seq no wait", 1'b0, data_wait_in);
        cmp_bit("seq cs", 1'b1, data_mem.cs);
        step();
        d_want = 1'b0;
        $display("t_dma_stall done");
    endtask : t_dma_stall

    // reset in the middle of a dma while the port wants an access, before any request is postponed
    task automatic t_reset;
        data_dma = {1'b1, 1'b0, 18'h00123, 4'h0, 32'h0};
        step();
        data_dma.valid = 1'b0;
        {d_want, d_seq, d_addr} = {1'b1, 1'b1, 18'h00077};
        step();
        {rst, d_want} = 2'b10;
        step();
        rst = 1'b0;
        cmp_bit("reset cs", 1'b0, data_mem.cs);
        cmp_bit("reset wait", 1'b0, data_wait_in);
        cmp_bit("reset done", 1'b0, data_dma_done);
        $display("t_reset done");
    endtask : t_reset

    task automatic t_instr;
        i_want = 1'b1;
        instr_dma = {1'b1, 1'b0, 18'h01234, 4'h0, 32'h0};
        #1;
        cmp_bit("instr wait", 1'b1, instr_wait_in);
        step();
        i_want = 1'b0;
        #1;
        cmp_bit("instr complete", 1'b0, instr_wait_in);
        cmp_bit("instr refused", 1'b0, instr_dma_accept);
        step();
        cmp_bit("instr wait again", 1'b1, instr_wait_in);
        cmp_bit("instr refused", 1'b0, instr_dma_accept);
        step();
        instr_dma.valid = 1'b0;
        cmp_bit("instr accept", 1'b1, instr_dma_accept);
        cmp_bit("instr cs", 1'b1, instr_mem.cs);
        cmp_word("instr addr", 32'h1234, {14'h0, instr_mem.addr});
        step(2);
        cmp_bit("instr done", 1'b1, instr_dma_done);
        cmp_word("instr rdata", 32'h00001234, instr_dma_rdata);
        $display("t_instr done");
    endtask : t_instr

    initial begin
        {rst, boot_strap, hivec_strap, standby_wait_for_irq} = 4'h8;
        {d_want, d_seq, d_addr, i_want} = '0;
        {data_byte_lane_mask, data_write_not_read, data_write_data} = '0;
        {instr_byte_lane_mask, instr_write_not_read, instr_write_data} = '0;
        {data_dma, instr_dma} = '0;
        step(4);
        rst = 1'b0;
        t_boot();
        t_dma_idle();
        t_dma_stall();
        t_reset();
        t_instr();
        stop_test();
    end

    initial begin
        #1000;
        num_errors++;
        $display("watchdog expired");
        stop_test();
    end
endmodule : tb
